//--- rtl/dcf_params.svh
// constants for the dual clock fifo with programmable flags
`ifndef DCF_PARAMS_SVH
`define DCF_PARAMS_SVH

// data path
`define DCF_DATA_W        9
`define DCF_DEPTH         512
`define DCF_ADDR_W        9
`define DCF_PTR_W         10
`define DCF_DEPTH_CNT     10'h200

// offset registers
`define DCF_OFF_W         8
`define DCF_OFF_LOW_RST   8'h07
`define DCF_OFF_HIGH_RST  8'h00

// staging buffer between pin capture and the array
`define DCF_STAGE_DEPTH   4

// input synchroniser and reset release
`define DCF_SYNC_STAGES   2
`define DCF_HOLD_W        3
`define DCF_HOLD_RST      3'h7

`endif

//--- rtl/dcf_pkg.sv
// types shared by the fifo design files
`include "dcf_params.svh"

package dcf_pkg;

	// offset register access sequence, one-hot
	typedef enum logic [3:0]
	{
		DCF_SEL_EMPTY_LOW  = 4'b0001,
		DCF_SEL_EMPTY_HIGH = 4'b0010,
		DCF_SEL_FULL_LOW   = 4'b0100,
		DCF_SEL_FULL_HIGH  = 4'b1000
	} dcf_sel_e;

	typedef logic [`DCF_PTR_W-1:0] dcf_ptr_t;

endpackage

//--- rtl/dcf_stage_fifo.sv
// small valid/ready staging fifo with registered read data
`include "dcf_params.svh"

module dcf_stage_fifo
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
)
(
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rstn,
	// fill side
	input  wire logic             i_valid,
	input  wire logic [WIDTH-1:0] i_data,
	output logic                  o_ready,
	// drain side
	output logic                  o_valid,
	output logic      [WIDTH-1:0] o_data,
	input  wire logic             i_ready
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wr_idx;
	logic [AW-1:0]    rd_idx;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign o_ready = (count != (AW+1)'(DEPTH));
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	always_ff @(posedge i_clk)
	begin
		if (push)
			store[wr_idx] <= i_data;
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wr_idx <= '0;
			rd_idx <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_idx <= wr_idx + 1'b1;
			if (pop)
				rd_idx <= rd_idx + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// head word is registered so the array write sees a flop
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_valid <= 1'b0;
			o_data  <= '0;
		end
		else if (!o_valid || i_ready)
		begin
			o_valid <= (count != '0) && !(pop && (count == (AW+1)'(1)));
			if (pop)
				o_data <= store[rd_idx + 1'b1];
			else
				o_data <= store[rd_idx];
		end
	end

endmodule

//--- rtl/dcf_fifo.sv
// dual clock 512 x 9 fifo with programmable almost flags
`include "dcf_params.svh"

module dcf_fifo
	import dcf_pkg::*;
(
	// system clock and reset pin
	input  wire logic                  i_clk,
	input  wire logic                  i_rstn,
	// write side pins
	input  wire logic                  i_wclk,
	input  wire logic [`DCF_DATA_W-1:0] i_push_data,
	input  wire logic                  i_primary_write_enable_n,
	input  wire logic                  i_second_enable_or_load,
	// read side pins
	input  wire logic                  i_rclk,
	input  wire logic                  i_read_enable_a_n,
	input  wire logic                  i_read_enable_b_n,
	input  wire logic                  i_output_enable_n,
	// data output, three-state
	output logic [`DCF_DATA_W-1:0]     o_pop_data,
	output logic                       o_pop_data_oe,
	// flags
	output logic                       o_empty_indicator_n,
	output logic                       o_full_indicator_n,
	output logic                       o_almost_empty_indicator_n,
	output logic                       o_almost_full_indicator_n
);

	// synchronisers: stage 0 is read only by stage 1
	logic [1:0]             wclk_s;
	logic [1:0]             rclk_s;
	logic [1:0]             wen_s;
	logic [1:0]             ld_s;
	logic [1:0]             ren_a_s;
	logic [1:0]             ren_b_s;
	logic [1:0]             oe_s;
	logic [`DCF_DATA_W-1:0] data_s0;
	logic [`DCF_DATA_W-1:0] data_s1;
	logic                   wclk_d;
	logic                   rclk_d;

	// mode and reset release
	logic [`DCF_HOLD_W-1:0] hold;
	logic                   in_reset;
	logic                   dual_mode;

	// pointers and flags
	dcf_ptr_t               wr_acc;
	dcf_ptr_t               wr_com;
	dcf_ptr_t               rd_ptr;
	dcf_ptr_t               next_wr_acc;
	dcf_ptr_t               next_rd_ptr;
	dcf_ptr_t               used_w;
	dcf_ptr_t               used_r;
	dcf_ptr_t               off_n;
	dcf_ptr_t               off_m;

	// offset registers and access sequence
	logic [`DCF_OFF_W-1:0]  empty_offset_low;
	logic [`DCF_OFF_W-1:0]  empty_offset_high;
	logic [`DCF_OFF_W-1:0]  full_offset_low;
	logic [`DCF_OFF_W-1:0]  full_offset_high;
	dcf_sel_e               sel;
	dcf_sel_e               next_sel;
	logic [`DCF_OFF_W-1:0]  sel_value;

	// events on the sampled pin clocks
	logic                   wedge;
	logic                   redge;
	logic                   wr_go;
	logic                   off_wr;
	logic                   rd_go;
	logic                   off_rd;
	logic                   rd_enabled;

	// staging buffer and array
	logic                   stage_ready;
	logic                   stage_valid;
	logic [`DCF_DATA_W-1:0] stage_data;
	logic                   drain;
	logic [`DCF_DATA_W-1:0] mem [`DCF_DEPTH];

	// pins sampled twice; no reset so the load strap is seen during reset
	always_ff @(posedge i_clk)
	begin
		wclk_s  <= {wclk_s[0], i_wclk};
		rclk_s  <= {rclk_s[0], i_rclk};
		wen_s   <= {wen_s[0], i_primary_write_enable_n};
		ld_s    <= {ld_s[0], i_second_enable_or_load};
		ren_a_s <= {ren_a_s[0], i_read_enable_a_n};
		ren_b_s <= {ren_b_s[0], i_read_enable_b_n};
		oe_s    <= {oe_s[0], i_output_enable_n};
		data_s0 <= i_push_data;
		data_s1 <= data_s0;
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wclk_d <= 1'b0;
			rclk_d <= 1'b0;
		end
		else
		begin
			wclk_d <= wclk_s[1];
			rclk_d <= rclk_s[1];
		end
	end

	assign wedge = wclk_s[1] && !wclk_d;
	assign redge = rclk_s[1] && !rclk_d;

	// a few cycles after release let the strap settle through the synchroniser
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			hold <= `DCF_HOLD_RST;
		else
			hold <= {hold[`DCF_HOLD_W-2:0], 1'b0};
	end

	assign in_reset = hold[`DCF_HOLD_W-1];

	// strap is latched by the clock, never by the asynchronous reset
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			dual_mode <= 1'b1;
		else if (in_reset)
			dual_mode <= ld_s[1];
	end

	// write side qualifiers
	// enable low and load/second enable high writes in both modes
	assign wr_go  = wedge && !in_reset && !wen_s[1] && ld_s[1]
	                && o_full_indicator_n && stage_ready;
	assign off_wr = wedge && !in_reset && !dual_mode && !wen_s[1] && !ld_s[1];

	// read side qualifiers
	assign rd_enabled = redge && !in_reset && !ren_a_s[1] && !ren_b_s[1];
	assign off_rd     = rd_enabled && !dual_mode && !ld_s[1];
	assign rd_go      = rd_enabled && !off_rd && o_empty_indicator_n;

	assign next_wr_acc = wr_acc + dcf_ptr_t'(wr_go);
	assign next_rd_ptr = rd_ptr + dcf_ptr_t'(rd_go);

	// other side's pointer is only looked at on this side's edge
	assign used_w = next_wr_acc - rd_ptr;
	assign used_r = wr_com - next_rd_ptr;

	// 9-bit thresholds; upper offset bits above the array size are dropped
	assign off_n = {1'b0, empty_offset_high[0], empty_offset_low};
	assign off_m = {1'b0, full_offset_high[0], full_offset_low};

	// accepted words queue up before the array
	dcf_stage_fifo
	#(
		.WIDTH (`DCF_DATA_W),
		.DEPTH (`DCF_STAGE_DEPTH)
	)
	u_stage
	(
		.i_clk   (i_clk),
		.i_rstn  (i_rstn),
		.i_valid (wr_go),
		.i_data  (data_s1),
		.o_ready (stage_ready),
		.o_valid (stage_valid),
		.o_data  (stage_data),
		.i_ready (!rd_go)
	);

	// array port is shared: a read stalls the drain for one cycle
	assign drain = stage_valid && !rd_go;

	always_ff @(posedge i_clk)
	begin
		if (drain)
			mem[wr_com[`DCF_ADDR_W-1:0]] <= stage_data;
	end

	// write pointers
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wr_acc <= '0;
			wr_com <= '0;
		end
		else
		begin
			wr_acc <= next_wr_acc;
			if (drain)
				wr_com <= wr_com + 1'b1;
		end
	end

	// read pointer
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			rd_ptr <= '0;
		else
			rd_ptr <= next_rd_ptr;
	end

	// full and almost-full move only on write clock edges
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_full_indicator_n        <= 1'b1;
			o_almost_full_indicator_n <= 1'b1;
		end
		else if (wedge)
		begin
			o_full_indicator_n        <= (used_w != `DCF_DEPTH_CNT);
			o_almost_full_indicator_n <= (used_w < (`DCF_DEPTH_CNT - off_m));
		end
	end

	// empty and almost-empty move only on read clock edges
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_empty_indicator_n        <= 1'b0;
			o_almost_empty_indicator_n <= 1'b0;
		end
		else if (redge)
		begin
			o_empty_indicator_n        <= (used_r != '0);
			o_almost_empty_indicator_n <= (used_r > off_n);
		end
	end

	// offset sequence, shared by loads and reads
	always_comb
	begin
		case (sel)
			DCF_SEL_EMPTY_LOW:
			begin
				next_sel  = DCF_SEL_EMPTY_HIGH;
				sel_value = empty_offset_low;
			end
			DCF_SEL_EMPTY_HIGH:
			begin
				next_sel  = DCF_SEL_FULL_LOW;
				sel_value = empty_offset_high;
			end
			DCF_SEL_FULL_LOW:
			begin
				next_sel  = DCF_SEL_FULL_HIGH;
				sel_value = full_offset_low;
			end
			DCF_SEL_FULL_HIGH:
			begin
				next_sel  = DCF_SEL_EMPTY_LOW;
				sel_value = full_offset_high;
			end
			default:
			begin
				next_sel  = DCF_SEL_EMPTY_LOW;
				sel_value = '0;
			end
		endcase
	end

	// position survives load going high; simultaneous access steps once
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			sel <= DCF_SEL_EMPTY_LOW;
		else if (off_wr || off_rd)
			sel <= next_sel;
	end

	// offset registers
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			empty_offset_low  <= `DCF_OFF_LOW_RST;
			empty_offset_high <= `DCF_OFF_HIGH_RST;
			full_offset_low   <= `DCF_OFF_LOW_RST;
			full_offset_high  <= `DCF_OFF_HIGH_RST;
		end
		else if (off_wr)
		begin
			case (sel)
				DCF_SEL_EMPTY_LOW:
					empty_offset_low <= data_s1[`DCF_OFF_W-1:0];
				DCF_SEL_EMPTY_HIGH:
					empty_offset_high <= data_s1[`DCF_OFF_W-1:0];
				DCF_SEL_FULL_LOW:
					full_offset_low <= data_s1[`DCF_OFF_W-1:0];
				DCF_SEL_FULL_HIGH:
					full_offset_high <= data_s1[`DCF_OFF_W-1:0];
				default:
					empty_offset_low <= empty_offset_low;
			endcase
		end
	end

	// output register holds the last read while empty
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_pop_data <= '0;
		else if (off_rd)
			o_pop_data <= {1'b0, sel_value};
		else if (rd_go)
			o_pop_data <= mem[rd_ptr[`DCF_ADDR_W-1:0]];
	end

	// pin level is resolved outside from this enable
	assign o_pop_data_oe = !oe_s[1];

endmodule

//--- sim/dcf_fifo_monitor.sv
// pin level checks for the dual clock fifo
`include "dcf_params.svh"

module dcf_fifo_monitor
(
	// clock and reset
	input wire logic                   i_clk,
	input wire logic                   i_rstn,
	// pins watched
	input wire logic                   i_wclk,
	input wire logic                   i_rclk,
	input wire logic                   i_output_enable_n,
	input wire logic [`DCF_DATA_W-1:0] o_pop_data,
	input wire logic                   o_pop_data_oe,
	input wire logic                   o_empty_indicator_n,
	input wire logic                   o_full_indicator_n,
	input wire logic                   o_almost_empty_indicator_n,
	input wire logic                   o_almost_full_indicator_n
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [2:0] wq;
	logic [2:0] rq;
	logic [7:0] wcnt;
	logic [7:0] rcnt;

	default clocking @(posedge i_clk);
	endclocking

	// pin clocks reach the design through flops, so count cycles since each rise
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wq   <= 3'h0;
			wcnt <= 8'hff;
		end
		else
		begin
			wq   <= {wq[1:0], i_wclk};
			wcnt <= (wq[1] && !wq[2]) ? 8'h00 : wcnt + 8'(wcnt != 8'hff);
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rq   <= 3'h0;
			rcnt <= 8'hff;
		end
		else
		begin
			rq   <= {rq[1:0], i_rclk};
			rcnt <= (rq[1] && !rq[2]) ? 8'h00 : rcnt + 8'(rcnt != 8'hff);
		end
	end

	sequence s_w_near;
		wcnt <= 8'h04;
	endsequence
	sequence s_r_near;
		rcnt <= 8'h05;
	endsequence
	sequence s_oe_steady;
		$stable(i_output_enable_n)[*3];
	endsequence

	property p_reset_state;
		!i_rstn |-> o_pop_data == 9'h000 && !o_empty_indicator_n
			&& !o_almost_empty_indicator_n && o_full_indicator_n && o_almost_full_indicator_n;
	endproperty
	property p_oe;
		disable iff (!i_rstn) s_oe_steady |-> o_pop_data_oe == !i_output_enable_n;
	endproperty
	property p_full_own_clk;
		disable iff (!i_rstn) $changed(o_full_indicator_n) |-> s_w_near;
	endproperty
	property p_af_own_clk;
		disable iff (!i_rstn) $changed(o_almost_full_indicator_n) |-> s_w_near;
	endproperty
	property p_ef_own_clk;
		disable iff (!i_rstn) $changed(o_empty_indicator_n) |-> s_r_near;
	endproperty
	property p_ae_own_clk;
		disable iff (!i_rstn) $changed(o_almost_empty_indicator_n) |-> s_r_near;
	endproperty
	property p_data_on_read;
		disable iff (!i_rstn) $changed(o_pop_data) |-> s_r_near;
	endproperty
	property p_full_is_af;
		disable iff (!i_rstn) !o_full_indicator_n |-> !o_almost_full_indicator_n;
	endproperty

	a_reset_state: assert property (p_reset_state)
		else $error("reset state wrong");
	a_oe: assert property (p_oe)
		else $error("output enable not followed");
	a_full_own_clk: assert property (p_full_own_clk)
		else $error("full moved without write clock");
	a_af_own_clk: assert property (p_af_own_clk)
		else $error("almost full moved without write clock");
	a_ef_own_clk: assert property (p_ef_own_clk)
		else $error("empty moved without read clock");
	a_ae_own_clk: assert property (p_ae_own_clk)
		else $error("almost empty moved without read clock");
	a_data_on_read: assert property (p_data_on_read)
		else $error("data moved without read clock");
	a_full_is_af: assert property (p_full_is_af)
		else $error("full without almost full");
endmodule

bind dcf_fifo dcf_fifo_monitor dcf_fifo_monitor_i
(
	.i_clk, .i_rstn, .i_wclk, .i_rclk, .i_output_enable_n, .o_pop_data, .o_pop_data_oe,
	.o_empty_indicator_n, .o_full_indicator_n, .o_almost_empty_indicator_n,
	.o_almost_full_indicator_n
);

//--- sim/dcf_host.sv
// writer and reader host model driving the fifo pins
`include "dcf_params.svh"

module dcf_host
(
	// timing reference
	input  wire logic                   i_clk,
	// write side
	output logic                        o_wclk,
	output logic [`DCF_DATA_W-1:0]      o_push_data,
	output logic                        o_wen_n,
	output logic                        o_ld,
	// read side
	output logic                        o_rclk,
	output logic                        o_ren_a_n,
	output logic                        o_ren_b_n
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		{o_wclk, o_rclk, o_push_data} = '0;
		{o_wen_n, o_ld, o_ren_a_n, o_ren_b_n} = 4'hf;
	end

	task automatic strap(input logic ld);
		o_ld = ld;
	endtask

	// 80 ns period with the caller's lead-in; pin clocks stand still between transfers
	task automatic pulse(input logic rd);
		@(negedge i_clk);
		if (rd)
			o_rclk = 1'b1;
		else
			o_wclk = 1'b1;
		repeat (5) @(negedge i_clk);
		o_rclk = 1'b0;
		o_wclk = 1'b0;
		repeat (3) @(negedge i_clk);
	endtask

	// writes and reads never overlap; each call drives its pins four clocks after the last release
	task automatic wr(input logic [8:0] d, input logic ld);
		@(negedge i_clk);
		o_push_data = d;
		o_ld = ld;
		o_wen_n = 1'b0;
		pulse(1'b0);
		o_wen_n = 1'b1;
		o_push_data = ~d;
	endtask

	task automatic rd(input logic ld, input logic ren_b_n);
		@(negedge i_clk);
		o_ld = ld;
		o_ren_a_n = 1'b0;
		o_ren_b_n = ren_b_n;
		pulse(1'b1);
		o_ren_a_n = 1'b1;
		o_ren_b_n = 1'b1;
	endtask
endmodule

//--- sim/tb.sv
// self-checking bench for the dual clock fifo
`include "dcf_params.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                   clk;
	logic                   rstn;
	logic                   oe_n;
	logic                   wclk, ld, wen_n, rclk, ren_a_n, ren_b_n;
	logic                   oe, ef_n, ff_n, ae_n, af_n;
	logic [`DCF_DATA_W-1:0] din;
	logic [`DCF_DATA_W-1:0] q;
	wire  [3:0]             flags = {ef_n, ff_n, ae_n, af_n};
	int                     errors;
	int                     cmp_count;

	initial clk = 1'b0;
	always #4 clk = ~clk;

	dcf_fifo dcf_fifo_i
	(
		.i_clk(clk), .i_rstn(rstn), .i_wclk(wclk), .i_push_data(din),
		.i_primary_write_enable_n(wen_n), .i_second_enable_or_load(ld), .i_rclk(rclk),
		.i_read_enable_a_n(ren_a_n), .i_read_enable_b_n(ren_b_n),
		.i_output_enable_n(oe_n), .o_pop_data(q), .o_pop_data_oe(oe),
		.o_empty_indicator_n(ef_n), .o_full_indicator_n(ff_n),
		.o_almost_empty_indicator_n(ae_n), .o_almost_full_indicator_n(af_n)
	);

	dcf_host dcf_host_i
	(
		.i_clk(clk), .o_wclk(wclk), .o_push_data(din), .o_wen_n(wen_n), .o_ld(ld),
		.o_rclk(rclk), .o_ren_a_n(ren_a_n), .o_ren_b_n(ren_b_n)
	);

	task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// host only sets the load strap while reset is low
	task automatic do_reset(input logic mode);
		@(negedge clk);
		rstn = 1'b0;
		dcf_host_i.strap(mode);
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		repeat (6) @(negedge clk);
		check(q, 9'h000, "reset data");
		check(9'(flags), 9'h005, "reset flags");
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		#400us;
		errors++;
		$display("CHECK FAILED t=%0t watchdog", $time);
		end_of_test();
	end

	initial
	begin
		errors = 0;
		cmp_count = 0;
		// high first, so that the reset pin sees a real falling edge
		rstn = 1'b1;
		oe_n = 1'b0;
		do_reset(1'b1);
		for (int i = 0; i < 8; i++)
			dcf_host_i.wr(9'(i * 3 + 1), 1'b1);
		dcf_host_i.wr(9'h1aa, 1'b0);
		dcf_host_i.rd(1'b1, 1'b1);
		check(q, 9'h000, "half enabled read");
		check(9'(flags), 9'h00f, "eight words");
		for (int i = 0; i < 9; i++)
		begin
			dcf_host_i.rd(1'b1, 1'b0);
			check(q, 9'(i < 8 ? i * 3 + 1 : 22), "read word");
		end
		check(9'(flags), 9'h005, "empty");
		oe_n = 1'b1;
		repeat (4) @(negedge clk);
		check(9'(oe), 9'h000, "released");
		oe_n = 1'b0;
		repeat (4) @(negedge clk);
		check(9'(oe), 9'h001, "driving");
		$display("test done: dual enable");
		for (int i = 0; i < 513; i++)
		begin
			dcf_host_i.wr(i == 512 ? 9'h1ff : 9'(i), 1'b1);
			if (i > 502)
				check(9'({ff_n, af_n}), 9'({i < 511, i < 504}), "fill flags");
		end
		// empty flag is still low here: the first read only raises it
		for (int i = 0; i < 514; i++)
		begin
			dcf_host_i.rd(1'b1, 1'b0);
			check(q, 9'(i == 0 ? 22 : (i < 513 ? i - 1 : 511)), "drain");
		end
		$display("test done: overflow");
		do_reset(1'b0);
		for (int i = 0; i < 4; i++)
		begin
			dcf_host_i.rd(1'b0, 1'b0);
			check(q, 9'(i[0] ? 0 : 7), "offset default");
		end
		dcf_host_i.wr(9'h003, 1'b0);
		dcf_host_i.wr(9'h0c5, 1'b1);
		dcf_host_i.wr(9'h000, 1'b0);
		dcf_host_i.wr(9'h005, 1'b0);
		dcf_host_i.wr(9'h000, 1'b0);
		for (int i = 0; i < 4; i++)
		begin
			dcf_host_i.rd(1'b0, 1'b0);
			check(q, 9'(i[0] ? 0 : 3 + i), "offset");
		end
		dcf_host_i.rd(1'b1, 1'b0);
		check(q, 9'h0c5, "flag mode word");
		for (int i = 0; i < 4; i++)
			dcf_host_i.wr(9'(i), 1'b1);
		dcf_host_i.rd(1'b1, 1'b1);
		check(9'(flags), 9'h00f, "programmed offset");
		$display("test done: programmable flags");
		end_of_test();
	end
endmodule
